// >>> verilog/power_mode_control.sv
// power mode controller: configuration register, mode sequencing, clock and pin control
`timescale 1ns/1ps
module power_mode_control #(
    parameter int KEY_LINES = 4,
    parameter int KEY_WAKE_CLOCKS = power_mode_pkg::KEY_WAKE_CLOCKS,
    parameter int TAKEOVER_CYCLES = power_mode_pkg::TAKEOVER_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    // special register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // core and interrupt controller
    input wire logic irq_pending,
    input wire logic [1:0] ext_irq_enable,
    input wire logic key_wake_enable,
    input wire logic internal_code,
    input wire logic supply_rise,
    // serial port
    input wire logic [1:0] serial_mode,
    input wire logic serial_mode_top_bit,
    input wire logic framing_error_flag,
    output logic baud_double_en,
    output logic serial_flag_select,
    output logic serial_top_read,
    // wake and reset pins
    input wire logic ext_irq_line_0_n,
    input wire logic ext_irq_line_1_n,
    input wire logic [KEY_LINES-1:0] keyboard_wake_input,
    input wire logic rst_pin,
    // clock control
    output logic osc_enable,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic exec_hold,
    output logic core_reset,
    output logic iram_block,
    output logic wake_irq,
    // pin control
    input wire logic ale_core,
    input wire logic program_strobe_core_n,
    input wire logic port0_drive_core,
    output logic ale_pin,
    output logic program_strobe_n,
    output logic port0_oe,
    output logic port_force_high
);
    localparam int TW = $clog2(TAKEOVER_CYCLES + 1);
    localparam int SW = KEY_LINES + 3;

    typedef struct packed {
        power_mode_pkg::mode_state_t state;
        logic [7:0] power_config_reg;
        logic [TW-1:0] takeover;
        logic key_start;
        logic osc_enable;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic exec_hold;
        logic core_reset;
        logic iram_block;
        logic wake_irq;
        logic [7:0] sfr_rdata;
        logic baud_double_en;
        logic serial_flag_select;
        logic serial_top_read;
        logic ale_pin;
        logic program_strobe_n;
        logic port0_oe;
        logic port_force_high;
    } ctl_state_t;

    localparam ctl_state_t CTL_RESET = '{
        state: power_mode_pkg::ST_RUN,
        power_config_reg: power_mode_pkg::POWER_CONFIG_REG_RESET,
        takeover: '0,
        key_start: 1'b0,
        osc_enable: 1'b1,
        cpu_clk_en: 1'b1,
        periph_clk_en: 1'b1,
        exec_hold: 1'b0,
        core_reset: 1'b0,
        iram_block: 1'b0,
        wake_irq: 1'b0,
        sfr_rdata: 8'h00,
        baud_double_en: 1'b0,
        serial_flag_select: 1'b0,
        serial_top_read: 1'b0,
        ale_pin: 1'b0,
        program_strobe_n: 1'b1,
        port0_oe: 1'b0,
        port_force_high: 1'b0
    };

    ctl_state_t st_r;
    ctl_state_t n;
    logic [SW-1:0] pins_s;
    logic ext0_s;
    logic ext1_s;
    logic [KEY_LINES-1:0] keys_s;
    logic rst_s;
    logic key_done;
    logic int_wake;
    logic key_wake;
    logic power_config_reg_wr;

    if (KEY_LINES < 1 || KEY_LINES > 8) begin : g_bad_keys
        $error("keyboard line count must be 1 to 8");
    end
    if (TAKEOVER_CYCLES < 1) begin : g_bad_takeover
        $error("takeover cycles must be at least one");
    end

    function automatic logic sfr_hit(input logic [7:0] addr);
        sfr_hit = (addr == power_mode_pkg::POWER_CONFIG_REG_OFFSET);
    endfunction

    // pins into the clock domain
    cdc_sync2 #(
        .WIDTH(SW)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ce(ce),
        .async_in({rst_pin, keyboard_wake_input, ext_irq_line_1_n, ext_irq_line_0_n}), // [RULE22]
        .sync_out(pins_s)
    );

    assign ext0_s = pins_s[0];
    assign ext1_s = pins_s[1];
    assign keys_s = pins_s[KEY_LINES+1:2];
    assign rst_s = pins_s[SW-1];

    // keyboard wake delay
    wake_delay_counter #(
        .COUNT(KEY_WAKE_CLOCKS)
    ) u_key_delay (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ce(ce),
        .start(st_r.key_start),
        .done(key_done)
    );

    // level wake: an enabled interrupt line held low, or, with keyboard wake enabled, any keyboard line held high
    assign int_wake = (!ext0_s && ext_irq_enable[0]) || (!ext1_s && ext_irq_enable[1]); // [RULE7]
    assign key_wake = key_wake_enable && (|keys_s);
    assign power_config_reg_wr = sfr_wr && sfr_hit(sfr_addr);

    always_comb begin
        n = st_r;
        n.wake_irq = 1'b0;
        n.key_start = 1'b0;
        case (st_r.state)
            power_mode_pkg::ST_RUN: begin
                if (irq_pending) begin
                    n.power_config_reg[power_mode_pkg::BIT_POWERDOWN] = 1'b0; // [RULE18]
                    n.power_config_reg[power_mode_pkg::BIT_IDLE] = 1'b0; // [RULE18]
                end
                if (power_config_reg_wr) begin
                    n.power_config_reg = sfr_wdata & power_mode_pkg::POWER_CONFIG_REG_WRITE_MASK; // [RULE17] [RULE20]
                    if (supply_rise) begin
                        n.power_config_reg[power_mode_pkg::BIT_POWER_OFF] = 1'b1; // [RULE16]
                    end
                    if (sfr_wdata[power_mode_pkg::BIT_POWERDOWN]) begin
                        n.state = power_mode_pkg::ST_PDOWN; // [RULE1] [RULE18]
                    end else if (sfr_wdata[power_mode_pkg::BIT_IDLE]) begin
                        n.state = power_mode_pkg::ST_IDLE; // [RULE21]
                    end
                end
            end
            power_mode_pkg::ST_IDLE: begin
                if (irq_pending) begin
                    n.power_config_reg[power_mode_pkg::BIT_IDLE] = 1'b0; // [RULE18]
                    n.power_config_reg[power_mode_pkg::BIT_POWERDOWN] = 1'b0;
                    n.state = power_mode_pkg::ST_RUN;
                    n.wake_irq = 1'b1; // [RULE6]
                end
            end
            power_mode_pkg::ST_PDOWN: begin
                if (int_wake) begin
                    n.power_config_reg[power_mode_pkg::BIT_POWERDOWN] = 1'b0; // [RULE3] [RULE8]
                    n.power_config_reg[power_mode_pkg::BIT_IDLE] = 1'b0;
                    n.state = power_mode_pkg::ST_WAKE_INT;
                end else if (key_wake) begin
                    n.power_config_reg[power_mode_pkg::BIT_POWERDOWN] = 1'b0; // [RULE3]
                    n.power_config_reg[power_mode_pkg::BIT_IDLE] = 1'b0;
                    n.state = power_mode_pkg::ST_WAKE_KEY;
                    n.key_start = 1'b1; // [RULE5]
                end
            end
            power_mode_pkg::ST_WAKE_INT: begin
                if (!int_wake) begin
                    n.state = power_mode_pkg::ST_RUN; // [RULE4]
                    n.wake_irq = 1'b1; // [RULE6]
                end
            end
            power_mode_pkg::ST_WAKE_KEY: begin
                if (!st_r.key_start && key_done) begin
                    n.state = power_mode_pkg::ST_RUN; // [RULE5]
                    n.wake_irq = 1'b1; // [RULE6]
                end
            end
            power_mode_pkg::ST_RST_RUN: begin
                if (st_r.takeover == TW'(TAKEOVER_CYCLES - 1)) begin
                    n.state = power_mode_pkg::ST_RESET; // [RULE9]
                end else begin
                    n.takeover = st_r.takeover + 1'b1;
                end
            end
            power_mode_pkg::ST_RESET: begin
                n.power_config_reg = st_r.power_config_reg & power_mode_pkg::POWER_CONFIG_REG_PIN_RESET_KEEP; // [RULE12]
                if (!rst_s) begin
                    n.state = power_mode_pkg::ST_RUN;
                end
            end
            default: begin
                n.state = power_mode_pkg::ST_RUN;
            end
        endcase
        // reset pin overrides every state except ST_RST_RUN, which runs on to ST_RESET
        if (rst_s) begin
            n.power_config_reg[power_mode_pkg::BIT_POWERDOWN] = 1'b0; // [RULE9] [RULE18]
            n.power_config_reg[power_mode_pkg::BIT_IDLE] = 1'b0; // [RULE18]
            n.wake_irq = 1'b0;
            if (st_r.state == power_mode_pkg::ST_PDOWN || st_r.state == power_mode_pkg::ST_IDLE) begin
                n.state = power_mode_pkg::ST_RST_RUN; // [RULE9] [RULE10]
                n.takeover = '0;
            end else if (st_r.state != power_mode_pkg::ST_RST_RUN) begin
                n.state = power_mode_pkg::ST_RESET;
            end
        end
        if (supply_rise) begin
            n.power_config_reg[power_mode_pkg::BIT_POWER_OFF] = 1'b1; // [RULE16]
        end
        // clock control follows the next state
        n.osc_enable = (n.state != power_mode_pkg::ST_PDOWN); // [RULE2] [RULE3] [RULE9]
        n.periph_clk_en = (n.state != power_mode_pkg::ST_PDOWN); // [RULE2] [RULE21]
        n.cpu_clk_en = (n.state != power_mode_pkg::ST_PDOWN)
            && (n.state != power_mode_pkg::ST_IDLE); // [RULE1] [RULE21]
        n.exec_hold = (n.state == power_mode_pkg::ST_WAKE_INT)
            || (n.state == power_mode_pkg::ST_WAKE_KEY); // [RULE4] [RULE5]
        n.core_reset = (n.state == power_mode_pkg::ST_RESET); // [RULE9] [RULE12]
        n.iram_block = (n.state == power_mode_pkg::ST_RST_RUN); // [RULE10]
        // pin states per mode
        case (n.state)
            power_mode_pkg::ST_RESET: begin
                n.port0_oe = 1'b0; // [RULE13]
                n.port_force_high = 1'b1;
                n.ale_pin = 1'b1;
                n.program_strobe_n = 1'b1;
            end
            power_mode_pkg::ST_IDLE: begin
                n.port0_oe = internal_code; // [RULE13]
                n.port_force_high = 1'b0;
                n.ale_pin = 1'b1;
                n.program_strobe_n = 1'b1;
            end
            power_mode_pkg::ST_PDOWN: begin
                n.port0_oe = internal_code; // [RULE13]
                n.port_force_high = 1'b0;
                n.ale_pin = 1'b0;
                n.program_strobe_n = 1'b0;
            end
            default: begin
                n.port0_oe = port0_drive_core;
                n.port_force_high = 1'b0;
                n.ale_pin = ale_core;
                n.program_strobe_n = program_strobe_core_n;
            end
        endcase
        // serial port controls
        n.baud_double_en = n.power_config_reg[power_mode_pkg::BIT_BAUD_DOUBLE]
            && (serial_mode != 2'h0); // [RULE14]
        n.serial_flag_select = n.power_config_reg[power_mode_pkg::BIT_FLAG_SELECT]; // [RULE15]
        n.serial_top_read = n.power_config_reg[power_mode_pkg::BIT_FLAG_SELECT]
            ? framing_error_flag : serial_mode_top_bit; // [RULE15]
        // register read
        n.sfr_rdata = (sfr_rd && sfr_hit(sfr_addr)) ? st_r.power_config_reg : 8'h00; // [RULE19]
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= CTL_RESET; // [RULE19]
        end else if (ce) begin
            st_r <= n;
        end
    end

    assign sfr_rdata = st_r.sfr_rdata;
    assign baud_double_en = st_r.baud_double_en;
    assign serial_flag_select = st_r.serial_flag_select;
    assign serial_top_read = st_r.serial_top_read;
    assign osc_enable = st_r.osc_enable;
    assign cpu_clk_en = st_r.cpu_clk_en;
    assign periph_clk_en = st_r.periph_clk_en;
    assign exec_hold = st_r.exec_hold;
    assign core_reset = st_r.core_reset;
    assign iram_block = st_r.iram_block;
    assign wake_irq = st_r.wake_irq;
    assign ale_pin = st_r.ale_pin;
    assign program_strobe_n = st_r.program_strobe_n;
    assign port0_oe = st_r.port0_oe;
    assign port_force_high = st_r.port_force_high;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_pd_entry_halt: assert property ( // [RULE1]
        ce && power_config_reg_wr && !rst_s && st_r.state == power_mode_pkg::ST_RUN
        && sfr_wdata[power_mode_pkg::BIT_POWERDOWN] |=> !cpu_clk_en && !osc_enable)
        else $error("power-down write did not halt clocks");

    a_pdown_clocks_off: assert property ( // [RULE2]
        st_r.state == power_mode_pkg::ST_PDOWN |-> !osc_enable && !cpu_clk_en && !periph_clk_en)
        else $error("clock running in power-down");

    a_ext_wake_restore: assert property ( // [RULE3]
        ce && st_r.state == power_mode_pkg::ST_PDOWN && int_wake && !rst_s
        |=> osc_enable && periph_clk_en && !st_r.power_config_reg[power_mode_pkg::BIT_POWERDOWN])
        else $error("external wake did not restore clocks");

    a_int_hold_release: assert property ( // [RULE4]
        ce && st_r.state == power_mode_pkg::ST_WAKE_INT && int_wake && !rst_s
        |=> exec_hold && !wake_irq)
        else $error("execution resumed with wake line still asserted");

    a_key_wait: assert property ( // [RULE5]
        $rose(st_r.state == power_mode_pkg::ST_WAKE_KEY) |-> exec_hold [*8])
        else $error("keyboard wake resumed too early");

    a_idle_irq_wake: assert property ( // [RULE6]
        ce && st_r.state == power_mode_pkg::ST_IDLE && irq_pending && !rst_s
        |=> wake_irq && st_r.state == power_mode_pkg::ST_RUN && cpu_clk_en)
        else $error("idle interrupt did not wake the core");

    a_ext_exit_keeps: assert property ( // [RULE8]
        $past(st_r.state) == power_mode_pkg::ST_PDOWN
        && st_r.state == power_mode_pkg::ST_WAKE_INT && !$past(supply_rise)
        |-> st_r.power_config_reg[7:2] == $past(st_r.power_config_reg[7:2]))
        else $error("external wake changed configuration bits");

    a_rst_clears_pd: assert property ( // [RULE9]
        ce && rst_s && st_r.state == power_mode_pkg::ST_PDOWN
        |=> st_r.state == power_mode_pkg::ST_RST_RUN && osc_enable
        && !st_r.power_config_reg[power_mode_pkg::BIT_POWERDOWN])
        else $error("reset pin did not leave power-down");

    a_rst_wake_block: assert property ( // [RULE10]
        st_r.state == power_mode_pkg::ST_RST_RUN |-> iram_block && !core_reset && cpu_clk_en)
        else $error("ram not blocked during reset takeover");

    a_reset_pof_kept: assert property ( // [RULE12]
        ce && st_r.state == power_mode_pkg::ST_RESET && !supply_rise
        |=> st_r.power_config_reg == ($past(st_r.power_config_reg) & power_mode_pkg::POWER_CONFIG_REG_PIN_RESET_KEEP))
        else $error("reset did not reinitialise configuration");

    a_reset_pins: assert property ( // [RULE13]
        core_reset |-> port_force_high && !port0_oe && ale_pin && program_strobe_n)
        else $error("pin states wrong in reset");

    a_pof_set_wins: assert property ( // [RULE16]
        ce && supply_rise |=> st_r.power_config_reg[power_mode_pkg::BIT_POWER_OFF])
        else $error("supply rise lost power-off flag");

    a_pd_precedence: assert property ( // [RULE18]
        ce && power_config_reg_wr && !rst_s && st_r.state == power_mode_pkg::ST_RUN
        && sfr_wdata[1:0] == 2'h3 |=> st_r.state == power_mode_pkg::ST_PDOWN)
        else $error("idle took precedence over power-down");

    a_reserved_zero: assert property ( // [RULE19]
        !st_r.power_config_reg[power_mode_pkg::BIT_RESERVED] && !sfr_rdata[power_mode_pkg::BIT_RESERVED])
        else $error("reserved bit set");

    c_int_wake: cover property (
        st_r.state == power_mode_pkg::ST_WAKE_INT ##1 st_r.state == power_mode_pkg::ST_RUN);
    c_key_wake: cover property (
        st_r.state == power_mode_pkg::ST_WAKE_KEY ##1 st_r.state == power_mode_pkg::ST_RUN);
    c_rst_wake: cover property (
        st_r.state == power_mode_pkg::ST_RST_RUN ##1 st_r.state == power_mode_pkg::ST_RESET);
    c_idle_wake: cover property (
        st_r.state == power_mode_pkg::ST_IDLE ##1 wake_irq);
endmodule

// >>> verilog/power_mode_pkg.sv
// power mode controller constants, states and operation summary
// Operation
// [RULE1] a power-down bit write is the last executed instruction before power-down
// [RULE2] power-down stops oscillator and all clocks, keeping cpu state and memories
// [RULE3] enabled external wake clears power-down, restarts oscillator, restores all clocks
// [RULE4] interrupt-line wake holds execution until the interrupt line is released
// [RULE5] keyboard wake holds execution for 1024 clocks of the restarted oscillator; the code holds it for KEY_WAKE_CLOCKS + 2, so 1026
// [RULE6] interrupt wake runs the service routine, then the instruction after power-down
// [RULE7] software makes the wake interrupt level-sensitive, top priority, held long enough
// [RULE8] external interrupt exit leaves special registers and internal ram unchanged
// [RULE9] reset pin high clears power-down, restarts oscillator, then core reset to 0000h
// [RULE10] brief execution after reset-pin wake blocks internal ram, allows port access
// [RULE11] software avoids port or external ram writes right after the power-down write
// [RULE12] reset exit reinitialises special registers but keeps internal ram contents
// [RULE13] pin states: reset drives high, idle and power-down hold, ale and strobe differ
// [RULE14] configuration bit 7 doubles serial baud rate in serial modes 1, 2, 3
// [RULE15] configuration bit 6 selects mode bit or framing-error flag at serial top bit
// [RULE16] power-off flag set on supply rise, software may set it or clear it
// [RULE17] bits 3 and 2 are plain software flags with no hardware effect
// [RULE18] interrupt or reset clears power-down and idle bits; power-down wins over idle
// [RULE19] configuration register resets to 00X1 0000b, undefined bit 5 reads as zero
// [RULE20] software never writes one to reserved bit 5 nor relies on its value
// [RULE21] idle stops cpu clock, peripherals keep running, all state preserved
// [RULE22] wake inputs are sensed from pins and synchronised before any logic uses them
package power_mode_pkg;
    localparam logic [7:0] POWER_CONFIG_REG_OFFSET = 8'h87;
    localparam int BIT_BAUD_DOUBLE = 7;
    localparam int BIT_FLAG_SELECT = 6;
    localparam int BIT_RESERVED = 5;
    localparam int BIT_POWER_OFF = 4;
    localparam int BIT_USER_ONE = 3;
    localparam int BIT_USER_ZERO = 2;
    localparam int BIT_POWERDOWN = 1;
    localparam int BIT_IDLE = 0;
    localparam logic [7:0] POWER_CONFIG_REG_RESET = 8'h10;
    localparam logic [7:0] POWER_CONFIG_REG_WRITE_MASK = 8'hdf;
    localparam logic [7:0] POWER_CONFIG_REG_PIN_RESET_KEEP = 8'h10;
    localparam int KEY_WAKE_CLOCKS = 1024;
    localparam int TAKEOVER_CYCLES = 4;
    typedef enum logic [6:0] {
        ST_RUN      = 7'h01,
        ST_IDLE     = 7'h02,
        ST_PDOWN    = 7'h04,
        ST_WAKE_INT = 7'h08,
        ST_WAKE_KEY = 7'h10,
        ST_RST_RUN  = 7'h20,
        ST_RESET    = 7'h40
    } mode_state_t;
endpackage

// >>> verilog/cdc_sync2.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module cdc_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;
    sync_state_t st_r;
    sync_state_t st_nxt;
    if (WIDTH < 1) begin : g_bad_width
        $error("synchroniser width must be at least one");
    end
    always_comb begin
        st_nxt.meta = async_in;
        st_nxt.stable = st_r.meta;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end
    assign sync_out = st_r.stable;
endmodule

// >>> verilog/wake_delay_counter.sv
// counter that flags done a fixed number of clocks after a start pulse
`timescale 1ns/1ps
module wake_delay_counter #(
    parameter int COUNT = 1024
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    // control
    input wire logic start,
    output logic done
);
    localparam int CW = $clog2(COUNT + 1);
    typedef struct packed {
        logic running;
        logic [CW-1:0] count;
        logic done;
    } cnt_state_t;
    cnt_state_t st_r;
    cnt_state_t st_nxt;
    if (COUNT < 2) begin : g_bad_count
        $error("count must be at least two");
    end
    always_comb begin
        st_nxt = st_r;
        if (start) begin
            st_nxt.running = 1'b1;
            st_nxt.count = '0;
            st_nxt.done = 1'b0;
        end else if (st_r.running) begin
            if (st_r.count == CW'(COUNT - 1)) begin // [RULE5]
                st_nxt.running = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.count = st_r.count + 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end
    assign done = st_r.done;
endmodule

// >>> verification/wake_pins_model.sv
// wake pins and reset pin driven by the external sources
`timescale 1ns/1ps
module wake_pins_model (
    // wake lines
    output logic ext_irq_line_0_n,
    output logic ext_irq_line_1_n,
    output logic [3:0] keyboard_wake_input,
    // reset pin
    output logic rst_pin
);
    // lines start released, held until the bench drives them
    initial begin
        ext_irq_line_0_n = 1'b1;
        ext_irq_line_1_n = 1'b1;
        keyboard_wake_input = 4'h0;
        rst_pin = 1'b0;
    end
    task automatic set_pins(input logic e0_n, input logic [3:0] k, input logic r);
        ext_irq_line_0_n = e0_n;
        keyboard_wake_input = k;
        rst_pin = r;
    endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 0, arst_n = 0, sfr_wr = 0, sfr_rd = 0, irq_pending = 0;
    logic key_wake_enable = 0, internal_code = 1, supply_rise = 0;
    logic smtb = 0, fef = 0, ce = 1, ale_core = 0, strobe_core_n = 1, port0_core = 0;
    logic [1:0] serial_mode = 2'h0, ext_irq_enable = 2'h0;
    logic [7:0] sfr_addr = 8'h87, sfr_wdata = 8'h00, sfr_rdata, d;
    logic baud_double_en, serial_flag_select, serial_top_read, osc_enable, cpu_clk_en;
    logic periph_clk_en, exec_hold, core_reset, iram_block, wake_irq, ale_pin;
    logic program_strobe_n, port0_oe, port_force_high, e0_n, e1_n, rst_pin;
    logic [3:0] keys;
    int miscompares = 0, n_tests = 0, cyc = 0, n;
    always #10 clk_sys = ~clk_sys;
    wake_pins_model p_u (.ext_irq_line_0_n(e0_n), .ext_irq_line_1_n(e1_n),
        .keyboard_wake_input(keys), .rst_pin(rst_pin));
    power_mode_control #(.KEY_LINES(4), .KEY_WAKE_CLOCKS(8), .TAKEOVER_CYCLES(4)) dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .irq_pending(irq_pending), .ext_irq_enable(ext_irq_enable),
        .key_wake_enable(key_wake_enable), .internal_code(internal_code),
        .supply_rise(supply_rise), .serial_mode(serial_mode), .serial_mode_top_bit(smtb),
        .framing_error_flag(fef), .baud_double_en(baud_double_en),
        .serial_flag_select(serial_flag_select), .serial_top_read(serial_top_read),
        .ext_irq_line_0_n(e0_n), .ext_irq_line_1_n(e1_n), .keyboard_wake_input(keys),
        .rst_pin(rst_pin), .osc_enable(osc_enable), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .exec_hold(exec_hold), .core_reset(core_reset),
        .iram_block(iram_block), .wake_irq(wake_irq), .ale_core(ale_core),
        .program_strobe_core_n(strobe_core_n), .port0_drive_core(port0_core), .ale_pin(ale_pin),
        .program_strobe_n(program_strobe_n), .port0_oe(port0_oe),
        .port_force_high(port_force_high));
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] v);
        sfr_addr = 8'h87;
        sfr_wdata = v;
        sfr_wr = 1;
        tick();
        sfr_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a);
        sfr_addr = a;
        sfr_rd = 1;
        tick();
        d = sfr_rdata;
        sfr_rd = 0;
    endtask
    task automatic t_regs();
        rd(8'h87); chk(d, 8'h10);
        wr(8'hdc); rd(8'h87); chk(d, 8'hdc);
        tick(); rd(8'h86); chk(d, 8'h00);
        ale_core = 1; strobe_core_n = 0; port0_core = 1; tick();
        chk({ale_pin, program_strobe_n, port0_oe}, 8'h05);
        serial_mode = 2'h1; fef = 1; tick();
        chk({baud_double_en, serial_flag_select, serial_top_read}, 8'h07);
        serial_mode = 2'h0; smtb = 1; tick();
        chk({baud_double_en, serial_flag_select, serial_top_read}, 8'h03);
        wr(8'h00); tick();
        chk({baud_double_en, serial_flag_select, serial_top_read}, 8'h01);
        supply_rise = 1; tick(); supply_rise = 0;
        rd(8'h87); chk(d, 8'h10);
        ce = 0; wr(8'h00); ce = 1;
        rd(8'h87); chk(d, 8'h10);
    endtask
    task automatic t_pdown_ext();
        ext_irq_enable = 2'h1;
        wr(8'h0f); tick();
        chk({osc_enable, cpu_clk_en, periph_clk_en}, 8'h00);
        chk({ale_pin, program_strobe_n, port0_oe}, 8'h01);
        p_u.set_pins(0, 4'h0, 0);
        for (n = 0; n < 20 && osc_enable !== 1; n++) tick();
        chk({osc_enable, cpu_clk_en, periph_clk_en, exec_hold}, 8'h0f);
        repeat (6) tick();
        chk(exec_hold, 8'h01);
        p_u.set_pins(1, 4'h0, 0);
        for (n = 0; n < 20 && wake_irq !== 1; n++) tick();
        chk({wake_irq, exec_hold}, 8'h02);
        rd(8'h87); chk(d, 8'h0c);
    endtask
    task automatic t_key();
        ext_irq_enable = 2'h0; key_wake_enable = 1;
        wr(8'h02); tick();
        p_u.set_pins(1, 4'h4, 0);
        for (n = 0; n < 20 && osc_enable !== 1; n++) tick();
        p_u.set_pins(1, 4'h0, 0);
        for (n = 0; n < 50 && exec_hold === 1; n++) tick();
        chk(8'(n), 8'd10);
        chk(wake_irq, 8'h01);
    endtask
    task automatic t_idle();
        internal_code = 0; wr(8'h01); tick();
        chk({cpu_clk_en, periph_clk_en, osc_enable, ale_pin, program_strobe_n, port0_oe},
            8'h1e);
        internal_code = 1; irq_pending = 1; tick(); irq_pending = 0;
        chk({cpu_clk_en, wake_irq}, 8'h03);
        rd(8'h87); chk(d, 8'h00);
    endtask
    task automatic t_rst_pin();
        wr(8'h1e); tick();
        p_u.set_pins(1, 4'h0, 1);
        for (n = 0; n < 20 && osc_enable !== 1; n++) tick();
        chk({iram_block, core_reset, cpu_clk_en}, 8'h05);
        for (n = 0; n < 20 && core_reset !== 1; n++) tick();
        chk({port_force_high, ale_pin, program_strobe_n, port0_oe}, 8'h0e);
        p_u.set_pins(1, 4'h0, 0);
        for (n = 0; n < 20 && core_reset !== 0; n++) tick();
        rd(8'h87); chk(d, 8'h10);
    endtask
    task automatic conclude();
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        repeat (10) tick();
        arst_n = 1;
        tick();
        t_regs();
        t_pdown_ext();
        t_key();
        t_idle();
        t_rst_pin();
        conclude();
    end
endmodule
